// ==== design/sensor_link_if.sv ====
// Interface carrying the four-wire serial port between controller and sensor
`timescale 1ns/1ps
interface sensor_link_if;
    logic sclk;
    logic ncs;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic hw_reset;
    modport sensor (
        input sclk,
        input ncs,
        input mosi,
        output miso,
        output miso_oe,
        input hw_reset
    );
    modport controller (
        output sclk,
        output ncs,
        output mosi,
        input miso,
        input miso_oe,
        output hw_reset
    );
endinterface

// ==== design/sensor_regs_controller.sv ====
// Controller end: drives the serial port to read and write sensor registers
`timescale 1ns/1ps
module sensor_regs_controller #(
    parameter int half_bit = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Serial link
    sensor_link_if.controller link,
    // Command port
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_hw_reset,
    output logic cmd_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata
);
    typedef enum {c_idle, c_shift, c_done} ctl_state_type;
    ctl_state_type state_r;
    logic [15:0] tx_r;
    logic [7:0] rx_r;
    logic [4:0] bits_r;
    logic [7:0] div_r;
    logic sclk_r;
    logic ncs_r;
    logic rsp_r;
    logic [7:0] rdata_r;
    logic hwr_r;
    wire tick = (div_r == 8'(half_bit - 1));

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r <= c_idle;
            tx_r <= 16'h0000;
            rx_r <= 8'h00;
            bits_r <= 5'h0;
            div_r <= 8'h00;
            sclk_r <= 1'b1;
            ncs_r <= 1'b1;
            rsp_r <= 1'b0;
            rdata_r <= 8'h00;
            hwr_r <= 1'b0;
        end else if (clk_en) begin
            rsp_r <= 1'b0;
            hwr_r <= cmd_hw_reset;
            case (state_r)
                c_idle: begin
                    div_r <= 8'h00;
                    if (cmd_valid) begin
                        tx_r <= {cmd_write, cmd_addr, cmd_wdata};
                        bits_r <= 5'h0;
                        ncs_r <= 1'b0;
                        state_r <= c_shift;
                    end
                end
                c_shift: begin
                    div_r <= tick ? 8'h00 : div_r + 8'h01;
                    if (tick) begin
                        sclk_r <= ~sclk_r;
                        if (!sclk_r) begin
                            if (bits_r >= 5'd8) begin
                                rx_r <= {rx_r[6:0], link.miso};
                            end
                            bits_r <= bits_r + 5'h1;
                            if (bits_r == 5'd15) begin
                                state_r <= c_done;
                            end
                        end else if (bits_r != 5'h0) begin
                            // Next bit on falling clock, so it stands across the rising edge
                            tx_r <= {tx_r[14:0], 1'b0};
                        end
                    end
                end
                c_done: begin
                    ncs_r <= 1'b1;
                    rsp_r <= 1'b1;
                    rdata_r <= rx_r;
                    state_r <= c_idle;
                end
                default: state_r <= c_idle;
            endcase
        end
    end

    assign link.sclk = sclk_r;
    assign link.ncs = ncs_r;
    assign link.mosi = tx_r[15];
    assign link.hw_reset = hwr_r;
    assign cmd_ready = (state_r == c_idle);
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdata_r;
endmodule

// ==== design/sensor_regs_device.sv ====
// Sensor end: test result, exposure, frame period, motion clear and pixel dump registers
`timescale 1ns/1ps
module sensor_regs_device #(
    parameter int self_test_len = sensor_regs_pkg::self_test_cycles,
    parameter int crc_test_len = sensor_regs_pkg::crc_test_cycles
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Serial link
    sensor_link_if.sensor link,
    // Image pipeline side
    input wire logic [7:0] pixel_mean,
    input wire logic [7:0] pixel_peak,
    input wire logic [7:0] mean_low_limit,
    input wire logic [7:0] peak_high_limit,
    input wire logic firmware_crc_ok,
    input wire logic hardware_ok,
    output logic frame_start,
    output logic motion_wipe,
    output logic navigation_halted,
    output logic firmware_lost,
    output logic pixel_capture_active,
    output logic test_busy
);
    typedef enum {st_idle, st_self_test, st_crc_test} test_state_type;

    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr_pulse;
    logic rd_pulse;
    logic [7:0] rdata;
    test_state_type test_state_r;
    logic [31:0] test_cnt_r;
    logic [15:0] result_r;
    logic [15:0] exposure_r;
    logic [15:0] exposure_max_r;
    logic [15:0] period_max_r;
    logic [15:0] period_cnt_r;
    logic [15:0] period_meas_r;
    logic [7:0] exp_max_low_stage_r;
    logic [7:0] period_low_stage_r;
    logic [7:0] ext_config_r;
    logic [7:0] pixel_dump_r;
    logic [7:0] exp_high_latch_r;
    logic [7:0] period_high_latch_r;
    logic halted_r;
    logic fw_lost_r;
    logic [1:0] capture_frames_r;
    logic frame_r;
    logic wipe_r;

    serial_byte_shifter u_shift (
        .ref_clk(ref_clk),
        .reset_n(reset_n & ~link.hw_reset),
        .clk_en(clk_en),
        .sclk(link.sclk),
        .ncs(link.ncs),
        .mosi(link.mosi),
        .miso(link.miso),
        .miso_oe(link.miso_oe),
        .addr(addr),
        .wdata(wdata),
        .wr_pulse(wr_pulse),
        .rd_pulse(rd_pulse),
        .rdata(rdata)
    );

    function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
        hit = (a == target);
    endfunction

    // ****************************************
    // Decode
    // ****************************************
    wire rst = ~reset_n | link.hw_reset;
    wire port_ok = (test_state_r == st_idle);
    wire wr_ok = wr_pulse & port_ok;
    wire start_self = wr_ok & hit(addr, sensor_regs_pkg::config_bits_addr) & wdata[sensor_regs_pkg::self_test_bit];
    wire start_crc = wr_ok & hit(addr, sensor_regs_pkg::firmware_gate_addr) &
        (wdata == sensor_regs_pkg::crc_start_code);
    wire wipe_hit = wr_ok & hit(addr, sensor_regs_pkg::displacement_wipe_addr);
    wire dump_hit = wr_ok & hit(addr, sensor_regs_pkg::pixel_dump_trigger_addr) &
        (wdata == sensor_regs_pkg::pixel_dump_code);
    wire auto_gain = ~ext_config_r[sensor_regs_pkg::gain_control_disable_bit];
    wire fixed_rate = ext_config_r[sensor_regs_pkg::fixed_rate_select_bit];
    wire frame_end = (period_cnt_r + 16'h0001 >= period_max_r);
    wire [15:0] step = {4'h0, exposure_r[15:4]} | {15'h0, exposure_r[15:4] == 12'h000};
    wire too_dark = pixel_mean < mean_low_limit;
    wire too_bright = pixel_peak > peak_high_limit;
    wire [16:0] up_sum = {1'b0, exposure_r} + {1'b0, step};
    wire [15:0] up_val = (up_sum > {1'b0, exposure_max_r}) ? exposure_max_r : up_sum[15:0];
    wire [15:0] down_val = (exposure_r > step) ? exposure_r - step : 16'h0001;
    wire [15:0] exposure_nxt = !auto_gain ? exposure_max_r :
        too_bright ? down_val : too_dark ? up_val :
        (exposure_r > exposure_max_r) ? exposure_max_r : exposure_r;

    // Read mux; upper byte read of exposure or measured period latches its lower byte for a coherent pair
    wire [7:0] rdata_sel =
        hit(addr, sensor_regs_pkg::test_result_high_addr) ? result_r[15:8] :
        hit(addr, sensor_regs_pkg::test_result_low_addr) ? result_r[7:0] :
        hit(addr, sensor_regs_pkg::exposure_high_addr) ? exposure_r[15:8] :
        hit(addr, sensor_regs_pkg::exposure_low_addr) ? exp_high_latch_r :
        hit(addr, sensor_regs_pkg::measured_period_high_addr) ? period_meas_r[15:8] :
        hit(addr, sensor_regs_pkg::measured_period_low_addr) ? period_high_latch_r :
        hit(addr, sensor_regs_pkg::pixel_dump_trigger_addr) ? pixel_dump_r :
        hit(addr, sensor_regs_pkg::ext_config_addr) ? ext_config_r :
        hit(addr, sensor_regs_pkg::period_max_high_addr) ? period_max_r[15:8] :
        hit(addr, sensor_regs_pkg::period_max_low_addr) ? period_max_r[7:0] : 8'h00;
    assign rdata = port_ok ? rdata_sel : 8'h00;

    // ****************************************
    // Test sequencer
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            test_state_r <= st_idle;
            test_cnt_r <= 32'h0;
            result_r <= 16'h0000;
        end else if (clk_en) begin
            case (test_state_r)
                st_idle: begin
                    test_cnt_r <= 32'h0;
                    if (start_self) begin
                        test_state_r <= st_self_test;
                    end else if (start_crc) begin
                        test_state_r <= st_crc_test;
                    end
                end
                st_self_test: begin
                    test_cnt_r <= test_cnt_r + 32'h1;
                    if (test_cnt_r + 32'h1 >= 32'(self_test_len)) begin
                        result_r <= hardware_ok ? sensor_regs_pkg::self_test_pass : 16'h0000;
                        test_state_r <= st_idle;
                    end
                end
                st_crc_test: begin
                    test_cnt_r <= test_cnt_r + 32'h1;
                    if (test_cnt_r + 32'h1 >= 32'(crc_test_len)) begin
                        result_r <= firmware_crc_ok ? sensor_regs_pkg::crc_test_pass : 16'h0000;
                        test_state_r <= st_idle;
                    end
                end
                default: test_state_r <= st_idle;
            endcase
        end
    end

    // ****************************************
    // Writable settings; self-test end restores defaults
    // ****************************************
    wire self_done = (test_state_r == st_self_test) && (test_cnt_r + 32'h1 >= 32'(self_test_len));
    always_ff @(posedge ref_clk) begin
        if (rst || (clk_en && self_done)) begin
            ext_config_r <= 8'h00;
            exposure_max_r <= sensor_regs_pkg::exposure_max_reset;
            period_max_r <= sensor_regs_pkg::period_max_reset;
            exp_max_low_stage_r <= sensor_regs_pkg::exposure_max_reset[7:0];
            period_low_stage_r <= sensor_regs_pkg::period_max_reset[7:0];
        end else if (clk_en && wr_ok) begin
            if (hit(addr, sensor_regs_pkg::ext_config_addr)) begin
                ext_config_r <= {6'h00, wdata[1:0]};
            end
            if (hit(addr, sensor_regs_pkg::exposure_max_low_addr)) begin
                exp_max_low_stage_r <= wdata;
            end
            if (hit(addr, sensor_regs_pkg::exposure_max_high_addr)) begin
                exposure_max_r <= {wdata, exp_max_low_stage_r};
            end
            if (hit(addr, sensor_regs_pkg::period_max_low_addr)) begin
                period_low_stage_r <= wdata;
            end
            if (hit(addr, sensor_regs_pkg::period_max_high_addr)) begin
                period_max_r <= {wdata, period_low_stage_r};
            end
        end
    end

    // ****************************************
    // Frame timing and exposure
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            period_cnt_r <= 16'h0000;
            period_meas_r <= sensor_regs_pkg::period_auto_reset;
            exposure_r <= sensor_regs_pkg::exposure_reset;
            frame_r <= 1'b0;
        end else if (clk_en) begin
            frame_r <= 1'b0;
            // Frames run on while halted so a pixel capture can finish
            if (frame_end) begin
                period_cnt_r <= 16'h0000;
                period_meas_r <= fixed_rate ? period_max_r : period_cnt_r + 16'h0001;
                exposure_r <= exposure_nxt;
                frame_r <= 1'b1;
            end else begin
                period_cnt_r <= period_cnt_r + 16'h0001;
            end
        end
    end

    // ****************************************
    // Read latches, motion wipe, pixel dump
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            exp_high_latch_r <= sensor_regs_pkg::exposure_reset[7:0];
            period_high_latch_r <= 8'h00;
            wipe_r <= 1'b0;
            pixel_dump_r <= sensor_regs_pkg::pixel_dump_reset;
            halted_r <= 1'b0;
            fw_lost_r <= 1'b0;
            capture_frames_r <= 2'h0;
        end else if (clk_en) begin
            wipe_r <= wipe_hit;
            if (rd_pulse && hit(addr, sensor_regs_pkg::exposure_high_addr)) begin
                exp_high_latch_r <= exposure_r[7:0];
            end
            if (rd_pulse && hit(addr, sensor_regs_pkg::measured_period_high_addr)) begin
                period_high_latch_r <= period_meas_r[7:0];
            end
            if (dump_hit) begin
                pixel_dump_r <= wdata;
                halted_r <= 1'b1;
                fw_lost_r <= 1'b1;
                capture_frames_r <= 2'(sensor_regs_pkg::pixel_dump_frames);
            end else if (frame_end && capture_frames_r != 2'h0) begin
                capture_frames_r <= capture_frames_r - 2'h1;
            end
            if (self_done) begin
                fw_lost_r <= 1'b1;
            end
        end
    end

    assign frame_start = frame_r;
    assign motion_wipe = wipe_r;
    assign navigation_halted = halted_r;
    assign firmware_lost = fw_lost_r;
    assign pixel_capture_active = capture_frames_r != 2'h0;
    assign test_busy = ~port_ok;
endmodule

// ==== design/sensor_regs_pkg.sv ====
// Package with register map, reset values and timing constants of the sensor register group
package sensor_regs_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [6:0] config_bits_addr = 7'h0a;
    localparam logic [6:0] ext_config_addr = 7'h0b;
    localparam logic [6:0] test_result_low_addr = 7'h0c;
    localparam logic [6:0] test_result_high_addr = 7'h0d;
    localparam logic [6:0] exposure_low_addr = 7'h0e;
    localparam logic [6:0] exposure_high_addr = 7'h0f;
    localparam logic [6:0] measured_period_low_addr = 7'h10;
    localparam logic [6:0] measured_period_high_addr = 7'h11;
    localparam logic [6:0] displacement_wipe_addr = 7'h12;
    localparam logic [6:0] pixel_dump_trigger_addr = 7'h13;
    localparam logic [6:0] firmware_gate_addr = 7'h14;
    localparam logic [6:0] exposure_max_low_addr = 7'h1d;
    localparam logic [6:0] exposure_max_high_addr = 7'h1e;
    localparam logic [6:0] period_max_low_addr = 7'h19;
    localparam logic [6:0] period_max_high_addr = 7'h1a;
    // ****************************************
    // Field positions and command values
    // ****************************************
    localparam int self_test_bit = 5;
    localparam int fixed_rate_select_bit = 0;
    localparam int gain_control_disable_bit = 1;
    localparam logic [7:0] crc_start_code = 8'ha1;
    localparam logic [7:0] pixel_dump_code = 8'h83;
    localparam logic [15:0] self_test_pass = 16'h1bbf;
    localparam logic [15:0] crc_test_pass = 16'hbeef;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] exposure_reset = 16'h0085;
    localparam logic [7:0] pixel_dump_reset = 8'h00;
    localparam logic [15:0] period_max_reset = 16'h2ee0;
    localparam logic [15:0] exposure_max_reset = 16'h1000;
    localparam logic [15:0] period_auto_reset = 16'h0e7e;
    // ****************************************
    // Timing
    // ****************************************
    localparam int clk_mhz = 10;
    localparam int self_test_ms = 200;
    localparam int self_test_cycles = self_test_ms * 1000 * clk_mhz;
    localparam int crc_test_us = 7000;
    localparam int crc_test_cycles = crc_test_us * clk_mhz;
    localparam int pixel_dump_frames = 2;
    // Serial command bit for writes
    localparam int write_flag_bit = 7;
endpackage

// ==== design/serial_byte_shifter.sv ====
// Byte shifter of the sensor serial port: collects address and data bytes, returns read data
`timescale 1ns/1ps
module serial_byte_shifter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Serial pins, sampled synchronously
    input wire logic sclk,
    input wire logic ncs,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    // Register side
    output logic [6:0] addr,
    output logic [7:0] wdata,
    output logic wr_pulse,
    output logic rd_pulse,
    input wire logic [7:0] rdata
);
    logic sclk_d_r;
    logic [2:0] bit_cnt_r;
    logic byte_idx_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic is_write_r;
    logic miso_r;
    logic wr_r;
    logic rd_r;
    logic [6:0] addr_r;
    logic [7:0] wdata_r;
    wire rise = sclk & ~sclk_d_r;
    wire fall = ~sclk & sclk_d_r;
    wire [7:0] shift_nxt = {shift_r[6:0], mosi};
    wire byte_done = rise & (bit_cnt_r == 3'h7);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sclk_d_r <= 1'b1;
            bit_cnt_r <= 3'h0;
            byte_idx_r <= 1'b0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            is_write_r <= 1'b0;
            miso_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= 7'h00;
            wdata_r <= 8'h00;
        end else if (clk_en) begin
            sclk_d_r <= sclk;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            if (ncs) begin
                bit_cnt_r <= 3'h0;
                byte_idx_r <= 1'b0;
            end else begin
                if (rise) begin
                    shift_r <= shift_nxt;
                    bit_cnt_r <= bit_cnt_r + 3'h1;
                end
                if (byte_done && !byte_idx_r) begin
                    addr_r <= shift_nxt[6:0];
                    is_write_r <= shift_nxt[sensor_regs_pkg::write_flag_bit];
                    rd_r <= ~shift_nxt[sensor_regs_pkg::write_flag_bit];
                    byte_idx_r <= 1'b1;
                end else if (byte_done) begin
                    wdata_r <= shift_nxt;
                    wr_r <= is_write_r;
                    byte_idx_r <= 1'b0;
                end
                if (rd_r) begin
                    tx_r <= rdata;
                end else if (fall && byte_idx_r && !is_write_r) begin
                    miso_r <= tx_r[7];
                    tx_r <= {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    assign addr = addr_r;
    assign wdata = wdata_r;
    assign wr_pulse = wr_r & clk_en;
    assign rd_pulse = rd_r & clk_en;
    assign miso = miso_r;
    assign miso_oe = ~ncs;
endmodule

// ==== sim/sensor_link_monitor.sv ====
// Checker of the serial link and the status outputs of the sensor end
`timescale 1ns/1ps
module sensor_link_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Serial link
    input wire logic sclk,
    input wire logic ncs,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic hw_reset,
    // Device status
    input wire logic frame_start,
    input wire logic motion_wipe,
    input wire logic navigation_halted,
    input wire logic firmware_lost,
    input wire logic pixel_capture_active
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence frame_open;
        $fell(ncs);
    endsequence
    sequence frame_body;
        !ncs [*8];
    endsequence
    oe_follows_cs_a: assert property (miso_oe == !ncs) else $error("miso enable differs");
    idle_clock_a: assert property (ncs && $past(ncs) |-> sclk) else $error("sclk low while idle");
    frame_hold_a: assert property (frame_open |-> frame_body) else $error("short frame");
    halt_sticky_a: assert property (navigation_halted && !hw_reset |=> navigation_halted)
        else $error("halt dropped");
    lost_sticky_a: assert property (firmware_lost && !hw_reset |=> firmware_lost)
        else $error("firmware flag dropped");
    wipe_pulse_a: assert property (motion_wipe |=> !motion_wipe) else $error("wipe too long");
    frame_pulse_a: assert property (frame_start |=> !frame_start) else $error("frame pulse too long");
    capture_halt_a: assert property (pixel_capture_active |-> navigation_halted)
        else $error("capture without halt");
    hw_reset_clear_a: assert property (hw_reset |=> !navigation_halted && !pixel_capture_active)
        else $error("reset kept halt");
endmodule

// ==== sim/sensor_regs_tb_top.sv ====
// Testbench joining controller and sensor ends over the serial link
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sensor_regs_tb_top;
    logic ref_clk, reset_n, cmd_valid, cmd_write, cmd_hw_reset, cmd_ready, rsp_valid;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_wdata, rsp_rdata, rd, pixel_mean, pixel_peak;
    logic frame_start, motion_wipe, navigation_halted, firmware_lost, pixel_capture_active, test_busy;
    logic clk_en, firmware_crc_ok, hardware_ok;
    int n_mismatch = 0, comparisons = 0, n_wipe = 0;
    time t0;
    logic [6:0] ra[5] = '{sensor_regs_pkg::exposure_high_addr, sensor_regs_pkg::exposure_low_addr,
        sensor_regs_pkg::pixel_dump_trigger_addr, sensor_regs_pkg::test_result_high_addr, 7'h7f};
    logic [7:0] re[5] = '{8'h00, 8'h85, 8'h00, 8'h00, 8'h00};
    sensor_link_if link();
    sensor_regs_device #(.self_test_len(20), .crc_test_len(10)) u_sensor_regs_device (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .link(link),
        .pixel_mean(pixel_mean), .pixel_peak(pixel_peak), .mean_low_limit(8'h10), .peak_high_limit(8'hf0),
        .firmware_crc_ok(firmware_crc_ok), .hardware_ok(hardware_ok), .frame_start(frame_start),
        .motion_wipe(motion_wipe),
        .navigation_halted(navigation_halted), .firmware_lost(firmware_lost),
        .pixel_capture_active(pixel_capture_active), .test_busy(test_busy));
    sensor_regs_controller u_sensor_regs_controller (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .link(link), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_hw_reset(cmd_hw_reset),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
    sensor_link_monitor u_sensor_link_monitor (
        .ref_clk(ref_clk), .reset_n(reset_n), .sclk(link.sclk), .ncs(link.ncs), .mosi(link.mosi),
        .miso(link.miso), .miso_oe(link.miso_oe), .hw_reset(link.hw_reset), .frame_start(frame_start),
        .motion_wipe(motion_wipe), .navigation_halted(navigation_halted), .firmware_lost(firmware_lost),
        .pixel_capture_active(pixel_capture_active));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (motion_wipe === 1'b1) n_wipe++;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic op(input logic w, input logic [6:0] a, input logic [7:0] d);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 200) begin @(negedge ref_clk); k++; end
        cmd_write = w; cmd_addr = a; cmd_wdata = d; cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        k = 0;
        while (rsp_valid !== 1'b1 && k < 200) begin @(negedge ref_clk); k++; end
        rd = rsp_rdata;
        @(negedge ref_clk);
    endtask
    task automatic chk_rd(input logic [6:0] a, input logic [7:0] e);
        op(1'b0, a, 8'h00);
        `CHK(rd, e)
    endtask
    task automatic wait_frame();
        int k;
        k = 0;
        do begin @(negedge ref_clk); k++; end while (frame_start !== 1'b1 && k < 20000);
    endtask
    task automatic wait_idle();
        int k;
        k = 0;
        repeat (2) @(negedge ref_clk);
        while (test_busy !== 1'b0 && k < 30000) begin @(negedge ref_clk); k++; end
    endtask
    task automatic hreset();
        cmd_hw_reset = 1'b1;
        repeat (3) @(negedge ref_clk);
        cmd_hw_reset = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        reset_n = 1'b0; cmd_valid = 1'b0; cmd_write = 1'b0; cmd_addr = 7'h00; cmd_wdata = 8'h00;
        cmd_hw_reset = 1'b0;
        clk_en = 1'b1;
        pixel_mean = 8'h80;
        pixel_peak = 8'h80;
        firmware_crc_ok = 1'b1;
        hardware_ok = 1'b1;
        repeat (3) @(negedge ref_clk);
        reset_n = 1'b1;
        for (int i = 0; i < 5; i++) chk_rd(ra[i], re[i]);
        op(1'b1, sensor_regs_pkg::exposure_max_low_addr, 8'h30);
        op(1'b1, sensor_regs_pkg::exposure_max_high_addr, 8'h00);
        op(1'b1, sensor_regs_pkg::period_max_low_addr, 8'h40);
        op(1'b1, sensor_regs_pkg::period_max_high_addr, 8'h00);
        // Auto exposure: one bright frame steps down, dark frames step up to the bound
        wait_frame();
        pixel_peak = 8'hff;
        wait_frame();
        pixel_peak = 8'h80;
        chk_rd(sensor_regs_pkg::exposure_high_addr, 8'h00);
        chk_rd(sensor_regs_pkg::exposure_low_addr, 8'h2d);
        pixel_mean = 8'h00;
        repeat (4) wait_frame();
        pixel_mean = 8'h80;
        chk_rd(sensor_regs_pkg::exposure_high_addr, 8'h00);
        chk_rd(sensor_regs_pkg::exposure_low_addr, 8'h30);
        op(1'b1, sensor_regs_pkg::ext_config_addr, 8'h03);
        repeat (3) wait_frame();
        t0 = $time;
        wait_frame();
        `CHK(int'(($time - t0) / 100), 64)
        // Clock enable low freezes the frame counter for 100 cycles
        wait_frame();
        t0 = $time;
        @(negedge ref_clk);
        clk_en = 1'b0;
        repeat (100) @(negedge ref_clk);
        clk_en = 1'b1;
        wait_frame();
        `CHK(int'(($time - t0) / 100), 164)
        chk_rd(sensor_regs_pkg::measured_period_high_addr, 8'h00);
        chk_rd(sensor_regs_pkg::measured_period_low_addr, 8'h40);
        chk_rd(sensor_regs_pkg::exposure_high_addr, 8'h00);
        chk_rd(sensor_regs_pkg::exposure_low_addr, 8'h30);
        op(1'b1, sensor_regs_pkg::displacement_wipe_addr, 8'h5a);
        repeat (2) @(negedge ref_clk);
        `CHK(n_wipe, 1)
        op(1'b1, sensor_regs_pkg::firmware_gate_addr, sensor_regs_pkg::crc_start_code);
        wait_idle();
        chk_rd(sensor_regs_pkg::test_result_high_addr, 8'hbe);
        chk_rd(sensor_regs_pkg::test_result_low_addr, 8'hef);
        chk_rd(sensor_regs_pkg::test_result_high_addr, 8'hbe);
        op(1'b1, sensor_regs_pkg::pixel_dump_trigger_addr, sensor_regs_pkg::pixel_dump_code);
        `CHK(navigation_halted, 1'b1)
        `CHK(pixel_capture_active, 1'b1)
        repeat (3) wait_frame();
        `CHK(pixel_capture_active, 1'b0)
        `CHK(navigation_halted, 1'b1)
        hreset();
        `CHK(navigation_halted, 1'b0)
        op(1'b1, sensor_regs_pkg::config_bits_addr, 8'h20);
        wait_idle();
        chk_rd(sensor_regs_pkg::test_result_high_addr, 8'h1b);
        chk_rd(sensor_regs_pkg::test_result_low_addr, 8'hbf);
        `CHK(firmware_lost, 1'b1)
        firmware_crc_ok = 1'b0;
        op(1'b1, sensor_regs_pkg::firmware_gate_addr, sensor_regs_pkg::crc_start_code);
        wait_idle();
        chk_rd(sensor_regs_pkg::test_result_high_addr, 8'h00);
        end_of_test();
    end
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_mismatch++;
        end_of_test();
    end
endmodule
